// [irsp_ctrl.sv]
// Pin ownership and control registers for the infrared serial interface
`default_nettype none
// Operation
// - Module enabled forces transmit pin to output regardless of port direction.
// - Module enabled forces receive pin to input regardless of port direction.
// - Module disabled returns both pins to general port control.
// - Transmitter disabled floats transmit pin after current character finishes.
// - Transmit pin carries infrared or standard serial, idling high.
// - Receive pin sampled only when receiver enabled; remote idles line high.
// - Loop mode feeds transmitter straight to receiver, skipping infrared codec.
// - Module enable runs logic and baud; clearing sets empty/done, blocks tx irq.
// - Character length bit selects nine or eight bit characters.
// - Wake bit selects address mark or idle line wakeup.
// - Idle type bit starts idle count after stop or after start bit.
// - Parity enable generates and checks parity in most significant bit.
// - Parity type selects odd when set, even when clear.
// - Frames have one start, one stop bit: ten or eleven bits total.
// - Transmit empty enable gates empty flag onto transmitter request; reset clears.
// - Completion enable gates done flag onto transmitter request; reset clears.
// - Receive full enable gates full flag onto receiver request; reset clears.
// - Reset clears loop, enable, length, wake, idle type, parity bits.
// - Setting transmit enable starts idle preamble; clearing lets character finish.
module irsp_ctrl
(
    input wire logic clk_sys, // System clock, 20 MHz
    input wire logic rst_b, // Asynchronous reset, active low
    input wire irsp_pkg::irsp_bus_s bus, // Register access request
    output logic [7:0] rdata, // Read data, cycle after read strobe
    input wire logic port_dir_bit_tx, // Port direction for transmit pin
    input wire logic port_dir_bit_rx, // Port direction for receive pin
    input wire logic port_out_tx, // Port data for transmit pin
    input wire logic port_out_rx, // Port data for receive pin
    input wire logic shared_tx_pin_i, // Transmit pin level
    input wire logic shared_rx_pin_i, // Receive pin level
    output logic shared_tx_pin_o, // Transmit pin output level (low only)
    output logic shared_tx_pin_oe, // Transmit pin pull-low enable
    output logic shared_rx_pin_o, // Receive pin output level
    output logic shared_rx_pin_oe, // Receive pin pull-low enable
    output logic port_in_tx, // Transmit pin level to port logic
    output logic port_in_rx, // Receive pin level to port logic
    input wire logic tx_serial, // Standard serial from shifter
    input wire logic tx_ir, // Infrared coded serial from encoder
    input wire logic tx_busy, // Character or preamble in flight
    input wire logic rx_decoded, // Infrared decoded receive level
    input wire logic tx_empty_in, // Empty flag from shifter logic
    input wire logic tx_done_in, // Done flag from shifter logic
    input wire logic rx_full_flag, // Receive full flag
    output logic rx_line, // Level fed to the receiver
    output logic module_enable, // Serial logic and baud enable
    output logic transmit_enable, // Transmitter enable
    output logic receive_enable, // Receiver enable
    output logic infrared_enable, // Infrared codec enable
    output logic preamble_start, // Pulse: begin idle preamble
    output irsp_pkg::irsp_fmt_s fmt, // Character format
    output logic tx_empty_flag, // Effective empty flag
    output logic tx_done_flag, // Effective done flag
    output logic tx_irq, // Transmitter interrupt request
    output logic rx_irq // Receiver interrupt request
);
    import irsp_pkg::*;

    logic [7:0] serial_control_one;
    logic [7:0] serial_control_two;
    logic [7:0] infrared_control_reg;
    logic tx_owned;
    logic [7:0] next_rdata;
    irsp_fmt_s next_fmt;
    irsp_pin_s next_tx_pin;
    irsp_pin_s next_rx_pin;

    wire wr_c1 = bus.wr && bus.addr == IRSP_OFF_CTRL1;
    wire wr_c2 = bus.wr && bus.addr == IRSP_OFF_CTRL2;
    wire wr_ir = bus.wr && bus.addr == IRSP_OFF_IRCTL;
    wire ena = serial_control_one[IRSP_C1_ENA];
    wire loop_select = serial_control_one[IRSP_C1_LOOP];
    wire tx_en_bit = serial_control_two[IRSP_C2_TXEN];
    wire rx_en_bit = serial_control_two[IRSP_C2_RXEN];
    wire ir_en = infrared_control_reg[IRSP_IR_EN];
    // Enable bits in control two only change while the module is enabled
    wire [7:0] c2_mask = ena ? 8'hFF : 8'hF3;
    wire [7:0] next_c2 = (bus.wdata & c2_mask) | (serial_control_two & ~c2_mask);
    // empty and done forced high while disabled
    wire empty_eff = tx_empty_in || !ena;
    wire done_eff = tx_done_in || !ena;
    // hold ownership until the character in flight is finished
    wire next_tx_owned = ena && (tx_en_bit || (tx_owned && tx_busy));
    // infrared selects the coded stream for the pin, loop mode or not
    wire tx_raw = tx_owned ? (ir_en ? tx_ir : tx_serial) : 1'b1;
    // pin or decoder only while receiving; loop takes the raw stream
    wire rx_source = ir_en ? rx_decoded : shared_rx_pin_i;
    wire next_rx_line = loop_select ? tx_serial : (rx_en_bit ? rx_source : 1'b1);
    wire [7:0] next_c1 = {bus.wdata[7:6], 1'b0, bus.wdata[4:0]};
    wire [7:0] next_c2_kept = {next_c2[7:2], 2'h0};
    wire [7:0] next_ir = {7'h00, bus.wdata[IRSP_IR_EN]};
    // preamble only on a zero-to-one transmit enable write while enabled
    wire next_preamble = wr_c2 && ena && next_c2[IRSP_C2_TXEN] && !tx_en_bit;
    // transmitter request, blocked while the module is off
    wire tx_req_empty = empty_eff && serial_control_two[IRSP_C2_TXEIE];
    wire tx_req_done = done_eff && serial_control_two[IRSP_C2_DONEIE];
    wire next_tx_irq = ena && (tx_req_empty || tx_req_done);
    // receiver request follows the flag while its enable is set
    wire next_rx_irq = rx_full_flag && serial_control_two[IRSP_C2_RXFIE];
    // Idle cycles read zero so software never sees a stale word
    wire [7:0] next_rdata_bus = bus.rd ? next_rdata : 8'h00;

    // transmit pin selection, open drain pulls only for a zero
    always_comb
    begin
        next_tx_pin.o = 1'b0;
        if (ena)
        begin
            next_tx_pin.oe = tx_owned && !tx_raw;
        end
        else
        begin
            next_tx_pin.oe = port_dir_bit_tx && !port_out_tx;
        end
    end

    // receive pin never driven while the module owns it
    always_comb
    begin
        next_rx_pin.o = 1'b0;
        next_rx_pin.oe = !ena && port_dir_bit_rx && !port_out_rx;
    end

    always_comb
    begin
        next_fmt.nine_bit = serial_control_one[IRSP_C1_M9];
        next_fmt.parity_en = serial_control_one[IRSP_C1_PAR];
        next_fmt.parity_odd = serial_control_one[IRSP_C1_ODD];
        next_fmt.wake_addr = serial_control_one[IRSP_C1_WAKE];
        next_fmt.idle_after_stop = serial_control_one[IRSP_C1_IDLE];
        next_fmt.frame_len = next_fmt.nine_bit ? IRSP_FRAME9 : IRSP_FRAME8;
        next_fmt.data_bits = next_fmt.frame_len - 4'h2 - {3'h0, next_fmt.parity_en};
    end

    always_comb
    begin
        case (bus.addr)
            IRSP_OFF_CTRL1: next_rdata = serial_control_one;
            IRSP_OFF_CTRL2: next_rdata = serial_control_two;
            IRSP_OFF_IRCTL: next_rdata = infrared_control_reg;
            IRSP_OFF_STAT: next_rdata = {4'h0, tx_owned, rx_full_flag, done_eff, empty_eff};
            default: next_rdata = 8'h00;
        endcase
    end

    // reset clears loop, enable, length, wake, idle type and parity bits
    always_ff @(posedge clk_sys or negedge rst_b)
    begin
        if (!rst_b)
        begin
            serial_control_one <= IRSP_CTRL1_RST;
        end
        else if (wr_c1)
        begin
            serial_control_one <= next_c1;
        end
    end

    // reset clears the request enables; writes follow the mask
    always_ff @(posedge clk_sys or negedge rst_b)
    begin
        if (!rst_b)
        begin
            serial_control_two <= IRSP_CTRL2_RST;
        end
        else if (wr_c2)
        begin
            serial_control_two <= next_c2_kept;
        end
    end

    // Infrared enable kept apart so the pin mux has a single source bit
    always_ff @(posedge clk_sys or negedge rst_b)
    begin
        if (!rst_b)
        begin
            infrared_control_reg <= IRSP_IRCTL_RST;
        end
        else if (wr_ir)
        begin
            infrared_control_reg <= next_ir;
        end
    end

    // ownership lags the enable bits by one clock, as the pins do
    always_ff @(posedge clk_sys or negedge rst_b)
    begin
        if (!rst_b)
        begin
            tx_owned <= 1'b0;
        end
        else
        begin
            tx_owned <= next_tx_owned;
        end
    end

    // Read word stands for exactly one cycle after the read strobe
    always_ff @(posedge clk_sys or negedge rst_b)
    begin
        if (!rst_b)
        begin
            rdata <= 8'h00;
        end
        else
        begin
            rdata <= next_rdata_bus;
        end
    end

    // open drain: the level is fixed low, only the enable moves
    always_ff @(posedge clk_sys or negedge rst_b)
    begin
        if (!rst_b)
        begin
            shared_tx_pin_o <= 1'b0;
            shared_tx_pin_oe <= 1'b0;
        end
        else
        begin
            shared_tx_pin_o <= next_tx_pin.o;
            shared_tx_pin_oe <= next_tx_pin.oe;
        end
    end

    // receive pin released whenever the module owns it
    always_ff @(posedge clk_sys or negedge rst_b)
    begin
        if (!rst_b)
        begin
            shared_rx_pin_o <= 1'b0;
            shared_rx_pin_oe <= 1'b0;
        end
        else
        begin
            shared_rx_pin_o <= next_rx_pin.o;
            shared_rx_pin_oe <= next_rx_pin.oe;
        end
    end

    // Pin levels to the port, one register so both paths share the delay
    always_ff @(posedge clk_sys or negedge rst_b)
    begin
        if (!rst_b)
        begin
            port_in_tx <= 1'b1;
            port_in_rx <= 1'b1;
        end
        else
        begin
            port_in_tx <= shared_tx_pin_i;
            port_in_rx <= shared_rx_pin_i;
        end
    end

    // receiver input idles high out of reset
    always_ff @(posedge clk_sys or negedge rst_b)
    begin
        if (!rst_b)
        begin
            rx_line <= 1'b1;
        end
        else
        begin
            rx_line <= next_rx_line;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_b)
    begin
        if (!rst_b)
        begin
            fmt <= IRSP_FMT_RST;
        end
        else
        begin
            fmt <= next_fmt;
        end
    end

    // enables to the shifters; transmit and receive gated by the module enable, infrared enable not gated
    always_ff @(posedge clk_sys or negedge rst_b)
    begin
        if (!rst_b)
        begin
            module_enable <= 1'b0;
            transmit_enable <= 1'b0;
            receive_enable <= 1'b0;
            infrared_enable <= 1'b0;
        end
        else
        begin
            module_enable <= ena;
            transmit_enable <= ena && tx_en_bit;
            receive_enable <= ena && rx_en_bit;
            infrared_enable <= ir_en;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_b)
    begin
        if (!rst_b)
        begin
            preamble_start <= 1'b0;
        end
        else
        begin
            preamble_start <= next_preamble;
        end
    end

    // flags read as set out of reset and while disabled
    always_ff @(posedge clk_sys or negedge rst_b)
    begin
        if (!rst_b)
        begin
            tx_empty_flag <= 1'b1;
            tx_done_flag <= 1'b1;
        end
        else
        begin
            tx_empty_flag <= empty_eff;
            tx_done_flag <= done_eff;
        end
    end

    // requests are registered so they change only on the clock
    always_ff @(posedge clk_sys or negedge rst_b)
    begin
        if (!rst_b)
        begin
            tx_irq <= 1'b0;
            rx_irq <= 1'b0;
        end
        else
        begin
            tx_irq <= next_tx_irq;
            rx_irq <= next_rx_irq;
        end
    end
endmodule
`default_nettype wire

// [irsp_pkg.sv]
// Package for the infrared serial pin and control block: offsets, fields, types
`default_nettype none
package irsp_pkg;
    // Register offsets
    localparam logic [1:0] IRSP_OFF_CTRL1 = 2'h0;
    localparam logic [1:0] IRSP_OFF_CTRL2 = 2'h1;
    localparam logic [1:0] IRSP_OFF_IRCTL = 2'h2;
    localparam logic [1:0] IRSP_OFF_STAT = 2'h3;
    // Control one bit positions
    localparam int IRSP_C1_LOOP = 7;
    localparam int IRSP_C1_ENA = 6;
    localparam int IRSP_C1_M9 = 4;
    localparam int IRSP_C1_WAKE = 3;
    localparam int IRSP_C1_IDLE = 2;
    localparam int IRSP_C1_PAR = 1;
    localparam int IRSP_C1_ODD = 0;
    // Control two and infrared control bit positions
    localparam int IRSP_C2_TXEIE = 7;
    localparam int IRSP_C2_DONEIE = 6;
    localparam int IRSP_C2_RXFIE = 5;
    localparam int IRSP_C2_TXEN = 3;
    localparam int IRSP_C2_RXEN = 2;
    localparam int IRSP_IR_EN = 0;
    // Reset values
    localparam logic [7:0] IRSP_CTRL1_RST = 8'h00;
    localparam logic [7:0] IRSP_CTRL2_RST = 8'h00;
    localparam logic [7:0] IRSP_IRCTL_RST = 8'h00;
    // Frame lengths in bits
    localparam logic [3:0] IRSP_FRAME8 = 4'hA;
    localparam logic [3:0] IRSP_FRAME9 = 4'hB;

    typedef struct packed {
        logic [1:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } irsp_bus_s;

    // Character format presented to the shifters
    typedef struct packed {
        logic nine_bit;
        logic parity_en;
        logic parity_odd;
        logic wake_addr;
        logic idle_after_stop;
        logic [3:0] frame_len;
        logic [3:0] data_bits;
    } irsp_fmt_s;

    // Format seen out of reset: eight bits, no parity, matches a cleared control one
    localparam irsp_fmt_s IRSP_FMT_RST = '{
        nine_bit: 1'b0,
        parity_en: 1'b0,
        parity_odd: 1'b0,
        wake_addr: 1'b0,
        idle_after_stop: 1'b0,
        frame_len: IRSP_FRAME8,
        data_bits: IRSP_FRAME8 - 4'h2
    };

    // Pin drive: output, enable (open drain: enable high pulls low)
    typedef struct packed {
        logic o;
        logic oe;
    } irsp_pin_s;
endpackage
`default_nettype wire

// [irsp_ctrl_assertions.sv]
// Assertions on pin ownership, flag gating and format of the control block
`default_nettype none
module irsp_ctrl_assertions
    import irsp_pkg::*;
(
    input wire logic clk_sys, // Clock
    input wire logic rst_b, // Reset
    input wire logic rx_full_flag, // Rx full
    input wire logic shared_rx_pin_oe, // Rx pull-low
    input wire logic module_enable, // Enable
    input wire logic transmit_enable, // Tx enable
    input wire logic receive_enable, // Rx enable
    input wire logic preamble_start, // Preamble
    input wire irsp_pkg::irsp_fmt_s fmt, // Format
    input wire logic tx_empty_flag, // Empty
    input wire logic tx_done_flag, // Done
    input wire logic tx_irq, // Tx request
    input wire logic rx_irq // Rx request
);
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!rst_b);
    property p_rx_in;
        module_enable && $past(module_enable) |-> !shared_rx_pin_oe;
    endproperty
    a_rx_in: assert property (p_rx_in) else $error("rx pin driven");
    property p_gate;
        transmit_enable || receive_enable |-> module_enable;
    endproperty
    a_gate: assert property (p_gate) else $error("enable not gated");
    property p_flags;
        !module_enable && !$past(module_enable) |-> tx_empty_flag && tx_done_flag;
    endproperty
    a_flags: assert property (p_flags) else $error("flags not forced");
    // Two cycles of margin for the flag register stage
    property p_irq_off;
        !module_enable && !$past(module_enable) && !$past(module_enable, 2) |-> !tx_irq;
    endproperty
    a_irq_off: assert property (p_irq_off) else $error("tx irq while disabled");
    property p_len;
        fmt.frame_len == (fmt.nine_bit ? IRSP_FRAME9 : IRSP_FRAME8);
    endproperty
    a_len: assert property (p_len) else $error("frame length");
    property p_bits;
        fmt.data_bits == (fmt.nine_bit ? 4'h9 : 4'h8) - {3'h0, fmt.parity_en};
    endproperty
    a_bits: assert property (p_bits) else $error("data bits");
    property p_rx_irq;
        rx_irq |-> $past(rx_full_flag) || $past(rx_full_flag, 2);
    endproperty
    a_rx_irq: assert property (p_rx_irq) else $error("rx irq without flag");
    property p_pre;
        preamble_start |=> !preamble_start;
    endproperty
    a_pre: assert property (p_pre) else $error("preamble not a pulse");
endmodule
bind irsp_ctrl irsp_ctrl_assertions u_chk (.clk_sys(clk_sys), .rst_b(rst_b),
    .rx_full_flag(rx_full_flag), .shared_rx_pin_oe(shared_rx_pin_oe),
    .module_enable(module_enable), .transmit_enable(transmit_enable),
    .receive_enable(receive_enable), .preamble_start(preamble_start), .fmt(fmt),
    .tx_empty_flag(tx_empty_flag), .tx_done_flag(tx_done_flag), .tx_irq(tx_irq),
    .rx_irq(rx_irq));
`default_nettype wire

// [irsp_remote.sv]
// Remote transceiver with pull-ups on both shared pins
`default_nettype none
module irsp_remote
(
    input wire logic clk_sys, // Clock
    input wire logic tx_oe, // Device pulls tx low
    input wire logic rx_oe, // Device pulls rx low
    output logic tx_pin, // Tx level
    output logic rx_pin // Rx level
);
    timeunit 1ns;
    timeprecision 1ns;
    logic remote_low = 1'b0;
    assign rx_pin = !(rx_oe || remote_low);
    assign tx_pin = !tx_oe;
    task automatic send_bit(input logic b);
        @(posedge clk_sys);
        remote_low <= !b;
    endtask
endmodule
`default_nettype wire

// [tb.sv]
// Testbench for the serial pin and control block
`default_nettype none
module tb
    import irsp_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    irsp_bus_s bus;
    irsp_fmt_s fmt;
    logic [7:0] rdata;
    logic clk_sys, rst_b, port_dir_bit_tx, port_dir_bit_rx, port_out_tx, port_out_rx, tx_ir;
    logic shared_tx_pin_i, shared_rx_pin_i, shared_tx_pin_o, shared_tx_pin_oe, tx_serial;
    logic shared_rx_pin_o, shared_rx_pin_oe, port_in_tx, port_in_rx, rx_line, tx_busy;
    logic rx_decoded, tx_empty_in, tx_done_in, rx_full_flag, module_enable, transmit_enable;
    logic receive_enable, infrared_enable, preamble_start, tx_empty_flag, tx_done_flag;
    logic tx_irq, rx_irq;
    int err_total = 0;
    int total_checks = 0;
    int c1 = 0;
    int c2 = 0;
    int ir = 0;
    int pulses;
    irsp_ctrl uut (.clk_sys(clk_sys), .rst_b(rst_b), .bus(bus), .rdata(rdata),
        .port_dir_bit_tx(port_dir_bit_tx), .port_dir_bit_rx(port_dir_bit_rx),
        .port_out_tx(port_out_tx), .port_out_rx(port_out_rx),
        .shared_tx_pin_i(shared_tx_pin_i), .shared_rx_pin_i(shared_rx_pin_i),
        .shared_tx_pin_o(shared_tx_pin_o), .shared_tx_pin_oe(shared_tx_pin_oe),
        .shared_rx_pin_o(shared_rx_pin_o), .shared_rx_pin_oe(shared_rx_pin_oe),
        .port_in_tx(port_in_tx), .port_in_rx(port_in_rx),
        .tx_serial(tx_serial), .tx_ir(tx_ir), .tx_busy(tx_busy),
        .rx_decoded(rx_decoded), .tx_empty_in(tx_empty_in),
        .tx_done_in(tx_done_in), .rx_full_flag(rx_full_flag), .rx_line(rx_line),
        .module_enable(module_enable), .transmit_enable(transmit_enable),
        .receive_enable(receive_enable), .infrared_enable(infrared_enable),
        .preamble_start(preamble_start), .fmt(fmt), .tx_empty_flag(tx_empty_flag),
        .tx_done_flag(tx_done_flag), .tx_irq(tx_irq), .rx_irq(rx_irq));
    irsp_remote u_rem (.clk_sys(clk_sys), .tx_oe(shared_tx_pin_oe), .rx_oe(shared_rx_pin_oe),
        .tx_pin(shared_tx_pin_i), .rx_pin(shared_rx_pin_i));
    initial
    begin
        clk_sys = 1'b0;
        forever #25 clk_sys = ~clk_sys;
    end
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        total_checks++;
        if (got !== exp)
        begin
            err_total++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [1:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge clk_sys);
        bus.wr <= 1'b0;
        if (a == IRSP_OFF_CTRL1)
            c1 = d & 8'hDF;
        // Enable bits keep their old value while the module is off
        if (a == IRSP_OFF_CTRL2)
            c2 = (d & 8'hF0) | ((c1[6] ? d : c2) & 8'h0C);
        if (a == IRSP_OFF_IRCTL)
            ir = d & 8'h01;
    endtask
    task automatic rd_chk(input logic [1:0] a, input logic [7:0] exp);
        @(posedge clk_sys);
        bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge clk_sys);
        bus.rd <= 1'b0;
        #1 chk(16'(rdata), 16'(exp));
    endtask
    task automatic check_all;
        logic own;
        repeat (3) @(posedge clk_sys);
        #1 own = c1[6] && c2[3];
        chk(shared_tx_pin_oe, c1[6] ? own && !(ir[0] ? tx_ir : tx_serial)
            : port_dir_bit_tx && !port_out_tx);
        chk(shared_rx_pin_oe, !c1[6] && port_dir_bit_rx && !port_out_rx);
        chk({shared_tx_pin_o, shared_rx_pin_o}, 2'h0);
        chk({transmit_enable, receive_enable, module_enable, infrared_enable},
            {own, c1[6] && c2[2], c1[6], ir[0]});
        chk(16'(fmt), {c1[4], c1[1], c1[0], c1[3], c1[2], c1[4] ? IRSP_FRAME9 : IRSP_FRAME8,
            4'(8 + c1[4] - c1[1])});
        chk({tx_empty_flag, tx_done_flag}, c1[6] ? {tx_empty_in, tx_done_in} : 2'h3);
        chk({tx_irq, rx_irq}, {c1[6] && (c2[7] && tx_empty_in || c2[6] && tx_done_in),
            c2[5] && rx_full_flag});
        if (c1[6])
            chk(rx_line, c1[7] ? tx_serial : !c2[2] || (ir[0] ? rx_decoded
                : shared_rx_pin_i));
        chk({port_in_tx, port_in_rx}, {shared_tx_pin_i, shared_rx_pin_i});
    endtask
    task automatic print_verdict;
        if (err_total == 0 && total_checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask
    initial
    begin
        #200000;
        err_total++;
        print_verdict();
    end
    initial
    begin
        bus = '0;
        rst_b = 1'b0;
        {port_dir_bit_tx, port_dir_bit_rx, port_out_tx, port_out_rx, tx_serial, tx_ir, tx_busy,
            rx_decoded, tx_empty_in, tx_done_in, rx_full_flag} = '0;
        void'($urandom(26));
        repeat (5) @(posedge clk_sys);
        rst_b <= 1'b1;
        rd_chk(IRSP_OFF_CTRL1, 8'h00);
        rd_chk(IRSP_OFF_CTRL2, 8'h00);
        wr(IRSP_OFF_CTRL2, 8'hFF);
        rd_chk(IRSP_OFF_CTRL2, 8'(c2));
        for (int i = 0; i < 48; i++)
        begin
            wr(IRSP_OFF_CTRL1, 8'($urandom) | (i % 4 ? 8'h40 : 8'h00));
            wr(IRSP_OFF_CTRL2, 8'($urandom) | (c1[7] ? 8'h0C : 8'h00));
            wr(IRSP_OFF_IRCTL, 8'($urandom));
            {port_dir_bit_tx, port_dir_bit_rx, port_out_tx, port_out_rx, tx_serial, tx_ir,
                rx_decoded, tx_empty_in, tx_done_in, rx_full_flag} <= 10'($urandom);
            u_rem.send_bit(1'($urandom));
            check_all();
            rd_chk(IRSP_OFF_CTRL1, 8'(c1));
            rd_chk(IRSP_OFF_CTRL2, 8'(c2));
        end
        wr(IRSP_OFF_CTRL1, 8'hC0);
        wr(IRSP_OFF_CTRL2, 8'h00);
        tx_busy <= 1'b1;
        pulses = 0;
        wr(IRSP_OFF_CTRL2, 8'h0C);
        repeat (4) @(posedge clk_sys) pulses += preamble_start;
        chk(16'(pulses), 16'h0001);
        check_all();
        rd_chk(IRSP_OFF_STAT, {4'h0, 1'b1, rx_full_flag, tx_done_in, tx_empty_in});
        wr(IRSP_OFF_CTRL2, 8'h04);
        repeat (3) @(posedge clk_sys);
        #1 chk(shared_tx_pin_oe, !(ir[0] ? tx_ir : tx_serial));
        @(posedge clk_sys) tx_busy <= 1'b0;
        check_all();
        wr(IRSP_OFF_CTRL1, 8'h00);
        check_all();
        rd_chk(IRSP_OFF_STAT, {5'h00, rx_full_flag, 2'h3});
        print_verdict();
    end
endmodule
`default_nettype wire
